// >>> rtl/dht_pkg.sv
package dht_pkg;

  // Structure selection codes
  localparam logic [2:0] CFG_JOINED = 3'h0;
  localparam logic [2:0] CFG_RTC    = 3'h1;
  localparam logic [2:0] CFG_SPLIT  = 3'h4;

  // Mode field codes of either half
  localparam logic [1:0] MODE_ONESHOT  = 2'h1;
  localparam logic [1:0] MODE_PERIODIC = 2'h2;

  // Reset and preset values
  localparam logic [15:0] RST_HALF     = 16'hffff;
  localparam logic [7:0]  RST_PRESCALE = 8'h00;
  localparam logic [2:0]  RST_CFG      = 3'h0;
  localparam logic [31:0] RTC_FIRST    = 32'h0000_0001;
  localparam logic [31:0] CNT_ZERO     = 32'h0000_0000;
  localparam logic [15:0] HALF_ZERO    = 16'h0000;
  localparam logic [15:0] HALF_ONE     = 16'h0001;
  localparam logic [31:0] WORD_ONE     = 32'h0000_0001;

  // Real-time clock source and tick rate
  localparam int unsigned PIN_CLK_HZ  = 32768;
  localparam int unsigned TICK_HZ     = 1;
  localparam int unsigned RTC_DIV_DEF = PIN_CLK_HZ / TICK_HZ;
  localparam int          PRE_W       = 16;

  typedef struct packed {
    logic clock_run_enable;
    logic second_stall_bit;
    logic second_trigger_enable;
    logic second_half_enable;
    logic first_stall_bit;
    logic output_trigger_enable;
    logic first_half_enable;
  } dht_ctl_t;

  localparam dht_ctl_t RST_CTL = '0;

  typedef struct packed {
    logic clock_match;
    logic second_timeout;
    logic first_timeout;
  } dht_irq_t;

  localparam dht_irq_t RST_IRQ = '0;

endpackage

// >>> rtl/dht_sync2.sv
`timescale 1ns/10ps
module dht_sync2 (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= 1'b0;
      q_o  <= 1'b0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule

// >>> rtl/dht_rtc_prescale.sv
`timescale 1ns/10ps
module dht_rtc_prescale #(
  parameter int unsigned DIV = dht_pkg::RTC_DIV_DEF
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic pin_sync_i,
  input  wire logic clear_i,
  output logic      tick_o
);
  localparam int           W    = dht_pkg::PRE_W;
  localparam logic [W-1:0] LAST = W'(DIV - 1);
  localparam logic [W-1:0] ONE  = W'(1);
  localparam logic [W-1:0] ZERO = W'(0);

  logic         pin_q;
  logic [W-1:0] cnt;
  logic         rise;

  assign rise = pin_sync_i & ~pin_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_q  <= 1'b0;
      cnt    <= ZERO;
      tick_o <= 1'b0;
    end else begin
      pin_q  <= pin_sync_i;
      tick_o <= 1'b0;
      if (clear_i) begin
        cnt <= ZERO;
      end else if (rise) begin
        if (cnt == LAST) begin
          cnt    <= ZERO;
          tick_o <= 1'b1;
        end else begin
          cnt <= cnt + ONE;
        end
      end
    end
  end
endmodule

// >>> rtl/dht_timer.sv
`timescale 1ns/10ps
// Behaviour
// - Two 16-bit counters, run split or joined as one 32-bit timer/clock.
// - Trigger is ORed with other timers outside; enable only one trigger source.
// - Reset: inactive, controls cleared, counters and loads 0xffff, prescales 0x00.
// - Structure code 0 joins one-shot/periodic timer, 1 joins real-time clock.
// - Structure code 0x4 splits into two independent 16-bit halves.
// - Joined codes act only as one 32-bit timer; split halves are independent.
// - Joined load write: low half to first load, high half to second.
// - Count read returns second half in upper, first half in lower halfword.
// - Joined one-shot/periodic choice uses first mode field only.
// - First enable starts joined down-count, one step per clock.
// - At zero the joined counter reloads concatenated load next cycle.
// - One-shot stops and clears enable after reload; periodic keeps counting.
// - Zero sets raw timeout flag, held until its clear bit is written.
// - Unmasked timeout also sets masked flag and raises the interrupt.
// - Trigger pulse at each timeout only while trigger enable is set.
// - Load rewrite while running is taken next clock, counting continues from it.
// - Stall bit freezes a timer counter until it drops; the clock mode counter ignores it.
// - Clock mode counts up; first selection presets the counter to 1.
// - Pin clock of 32.768 kHz divided to a 1 Hz counting tick.
// - Clock counts up, rolls to zero on match, runs until disabled.
// - Match sets raw flag, and if unmasked also masked flag and interrupt; clear bit drops both.
// - With clock run enable set, stall bits are ignored.
module dht_timer #(
  parameter int unsigned RTC_DIV = dht_pkg::RTC_DIV_DEF
) (
  input  wire logic              CORE_CLK_I,
  input  wire logic              RST_N_I,
  input  wire logic              CFG_WR_I,
  input  wire logic [2:0]        CFG_I,
  input  wire logic [1:0]        FIRST_MODE_I,
  input  wire logic [1:0]        SECOND_MODE_I,
  input  wire logic              CTL_WR_I,
  input  wire dht_pkg::dht_ctl_t CTL_I,
  input  wire logic              LOAD_WR_I,
  input  wire logic [31:0]       LOAD_I,
  input  wire logic              SECOND_LOAD_WR_I,
  input  wire logic [15:0]       SECOND_LOAD_I,
  input  wire logic              MATCH_WR_I,
  input  wire logic [31:0]       MATCH_I,
  input  wire logic              PRESCALE_WR_I,
  input  wire logic [15:0]       PRESCALE_I,
  input  wire dht_pkg::dht_irq_t MASK_I,
  input  wire logic              ICR_WR_I,
  input  wire dht_pkg::dht_irq_t ICR_I,
  input  wire logic              CAPTURE_PIN_I,
  output logic [2:0]             CFG_O,
  output dht_pkg::dht_ctl_t      CTL_O,
  output logic [31:0]            LOAD_O,
  output logic [31:0]            COUNT_O,
  output logic [31:0]            MATCH_O,
  output logic [15:0]            PRESCALE_O,
  output dht_pkg::dht_irq_t      RAW_O,
  output dht_pkg::dht_irq_t      MIS_O,
  output logic                   IRQ_O,
  output logic                   TRIG_O
);

  function automatic logic [15:0] step_down(input logic [15:0] v);
    step_down = v - dht_pkg::HALF_ONE;
  endfunction

  logic [2:0]        cfg;
  dht_pkg::dht_ctl_t ctl;
  logic [15:0]       load_lo;
  logic [15:0]       load_hi;
  logic [15:0]       cnt_lo;
  logic [15:0]       cnt_hi;
  logic [31:0]       match;
  logic [7:0]        pre_lo;
  logic [7:0]        pre_hi;
  logic              rtc_seen;
  dht_pkg::dht_irq_t raw;

  logic              joined, rtc, split;
  logic              stall_a, stall_b;
  logic              run32, rtc_run, runa, runb;
  logic              to32, toa, tob, match_evt;
  logic              oneshot_a, oneshot_b, rtc_first;
  logic [31:0]       cnt32;
  logic              pin_s, tick;
  logic [15:0]       next_lo, next_hi;
  dht_pkg::dht_irq_t next_raw;

  assign cfg     = CFG_O;
  assign ctl     = CTL_O;
  assign cnt32   = {cnt_hi, cnt_lo};
  assign COUNT_O = {cnt_hi, cnt_lo};
  assign LOAD_O  = {load_hi, load_lo};
  assign MATCH_O = match;
  assign PRESCALE_O = {pre_hi, pre_lo};
  assign RAW_O   = raw;

  assign joined  = (cfg == dht_pkg::CFG_JOINED);
  assign rtc     = (cfg == dht_pkg::CFG_RTC);
  assign split   = (cfg == dht_pkg::CFG_SPLIT);
  // Stall is meaningless once the wall clock runs
  assign stall_a = ctl.first_stall_bit & ~ctl.clock_run_enable;
  assign stall_b = ctl.second_stall_bit & ~ctl.clock_run_enable;
  assign oneshot_a = (FIRST_MODE_I == dht_pkg::MODE_ONESHOT);
  assign oneshot_b = (SECOND_MODE_I == dht_pkg::MODE_ONESHOT);

  assign run32   = joined & ctl.first_half_enable & ~stall_a;
  assign rtc_run = rtc & ctl.first_half_enable;
  assign runa    = split & ctl.first_half_enable & ~stall_a;
  assign runb    = split & ctl.second_half_enable & ~stall_b;
  assign to32    = run32 & (cnt32 == dht_pkg::CNT_ZERO);
  assign toa     = runa & (cnt_lo == dht_pkg::HALF_ZERO);
  assign tob     = runb & (cnt_hi == dht_pkg::HALF_ZERO);
  assign match_evt = rtc_run & tick & (cnt32 == match);
  assign rtc_first = CFG_WR_I & (CFG_I == dht_pkg::CFG_RTC) & ~rtc_seen;

  dht_sync2 u_pin_sync (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (RST_N_I),
    .d_i     (CAPTURE_PIN_I),
    .q_o     (pin_s)
  );

  dht_rtc_prescale #(.DIV(RTC_DIV)) u_prescale (
    .clk_i      (CORE_CLK_I),
    .rst_n_i    (RST_N_I),
    .pin_sync_i (pin_s),
    .clear_i    (~rtc_run),
    .tick_o     (tick)
  );

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      CFG_O    <= dht_pkg::RST_CFG;
      rtc_seen <= 1'b0;
    end else if (CFG_WR_I) begin
      CFG_O <= CFG_I;
      if (CFG_I == dht_pkg::CFG_RTC) begin
        rtc_seen <= 1'b1;
      end
    end
  end

  // Software write lands after the hardware clear, so a same-cycle rewrite wins
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      CTL_O <= dht_pkg::RST_CTL;
    end else if (CTL_WR_I) begin
      CTL_O <= CTL_I;
    end else begin
      if ((to32 || toa) && oneshot_a) begin
        CTL_O.first_half_enable <= 1'b0;
      end
      if (tob && oneshot_b) begin
        CTL_O.second_half_enable <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      load_lo <= dht_pkg::RST_HALF;
      load_hi <= dht_pkg::RST_HALF;
    end else begin
      if (LOAD_WR_I) begin
        load_lo <= LOAD_I[15:0];
      end
      if (LOAD_WR_I && !split) begin
        load_hi <= LOAD_I[31:16];
      end else if (SECOND_LOAD_WR_I) begin
        load_hi <= SECOND_LOAD_I;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      match <= dht_pkg::CNT_ZERO;
    end else if (MATCH_WR_I) begin
      match <= MATCH_I;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pre_lo <= dht_pkg::RST_PRESCALE;
      pre_hi <= dht_pkg::RST_PRESCALE;
    end else if (PRESCALE_WR_I) begin
      pre_lo <= PRESCALE_I[7:0];
      pre_hi <= PRESCALE_I[15:8];
    end
  end

  // Counter next value; a load write beats the reload and the step
  always_comb begin
    next_lo = cnt_lo;
    next_hi = cnt_hi;
    if (rtc_first) begin
      {next_hi, next_lo} = dht_pkg::RTC_FIRST;
    end else if (split) begin
      if (LOAD_WR_I) begin
        next_lo = LOAD_I[15:0];
      end else if (toa) begin
        next_lo = load_lo;
      end else if (runa) begin
        next_lo = step_down(cnt_lo);
      end
      if (SECOND_LOAD_WR_I) begin
        next_hi = SECOND_LOAD_I;
      end else if (tob) begin
        next_hi = load_hi;
      end else if (runb) begin
        next_hi = step_down(cnt_hi);
      end
    end else if (LOAD_WR_I && joined) begin
      {next_hi, next_lo} = LOAD_I;
    end else if (to32) begin
      {next_hi, next_lo} = {load_hi, load_lo};
    end else if (run32) begin
      {next_hi, next_lo} = cnt32 - dht_pkg::WORD_ONE;
    end else if (rtc_run && tick) begin
      if (match_evt) begin
        {next_hi, next_lo} = dht_pkg::CNT_ZERO;
      end else begin
        {next_hi, next_lo} = cnt32 + dht_pkg::WORD_ONE;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cnt_lo <= dht_pkg::RST_HALF;
      cnt_hi <= dht_pkg::RST_HALF;
    end else begin
      cnt_lo <= next_lo;
      cnt_hi <= next_hi;
    end
  end

  // An event in the clearing cycle survives the clear
  always_comb begin
    next_raw = raw;
    if (ICR_WR_I) begin
      next_raw = raw & ~ICR_I;
    end
    next_raw.first_timeout  = next_raw.first_timeout | to32 | toa;
    next_raw.second_timeout = next_raw.second_timeout | tob;
    next_raw.clock_match    = next_raw.clock_match | match_evt;
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      raw   <= dht_pkg::RST_IRQ;
      MIS_O <= dht_pkg::RST_IRQ;
      IRQ_O <= 1'b0;
    end else begin
      raw   <= next_raw;
      MIS_O <= next_raw & MASK_I;
      IRQ_O <= |(next_raw & MASK_I);
    end
  end

  // Combining with other timers' triggers happens outside this block
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      TRIG_O <= 1'b0;
    end else begin
      TRIG_O <= ((to32 | toa) & ctl.output_trigger_enable)
              | (tob & ctl.second_trigger_enable);
    end
  end

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);

  reload_zero_a: assert property (
    to32 && !LOAD_WR_I && !CFG_WR_I |=> COUNT_O == $past(LOAD_O))
    else $error("joined counter did not reload at zero");
  oneshot_stop_a: assert property (
    to32 && oneshot_a && !CTL_WR_I |=> !CTL_O.first_half_enable
      ##1 ($stable(COUNT_O) || $past(LOAD_WR_I) || $past(CFG_WR_I)))
    else $error("one-shot did not stop");
  periodic_run_a: assert property (
    to32 && !oneshot_a && !CTL_WR_I |=> CTL_O.first_half_enable)
    else $error("periodic lost its enable");
  down_step_a: assert property (
    run32 && !to32 && !LOAD_WR_I && !CFG_WR_I
      |=> COUNT_O == $past(COUNT_O) - dht_pkg::WORD_ONE)
    else $error("joined counter did not step down");
  timeout_hold_a: assert property (
    to32 ##1 !(ICR_WR_I && ICR_I.first_timeout) |-> RAW_O.first_timeout ##1 RAW_O.first_timeout)
    else $error("timeout flag not held");
  masked_irq_a: assert property (
    to32 && MASK_I.first_timeout |=> MIS_O.first_timeout && IRQ_O && RAW_O.first_timeout)
    else $error("masked timeout missing");
  trig_pulse_a: assert property (
    (to32 || toa) && !tob |=> TRIG_O == $past(ctl.output_trigger_enable))
    else $error("trigger does not follow timeout");
  load_take_a: assert property (
    LOAD_WR_I && joined && !rtc_first |=> COUNT_O == $past(LOAD_I) && LOAD_O == $past(LOAD_I))
    else $error("load write not taken next clock");
  stall_hold_a: assert property (
    joined && stall_a && !LOAD_WR_I && !CFG_WR_I |=> $stable(COUNT_O))
    else $error("stalled counter moved");
  rtc_first_a: assert property (
    rtc_first |=> COUNT_O == dht_pkg::RTC_FIRST)
    else $error("first clock selection did not preset one");
  rtc_roll_a: assert property (
    match_evt && !rtc_first |=> COUNT_O == dht_pkg::CNT_ZERO && RAW_O.clock_match)
    else $error("clock did not roll over on match");
  rtc_nostall_a: assert property (
    rtc_run && tick && !match_evt && !CFG_WR_I && ctl.first_stall_bit
      |=> COUNT_O == $past(COUNT_O) + dht_pkg::WORD_ONE)
    else $error("clock froze under stall");

  oneshot_c: cover property (to32 && oneshot_a);
  periodic_c: cover property (to32 && !oneshot_a ##[1:20] to32);
  rtc_match_c: cover property (match_evt);
  split_both_c: cover property (toa && tob);

endmodule

// >>> tb/dual_half_timer_32bit_modes_bench.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module dual_half_timer_32bit_modes_bench;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              cfg_wr = 1'b0, ctl_wr = 1'b0, load_wr = 1'b0, load2_wr = 1'b0;
  logic              match_wr = 1'b0, pre_wr = 1'b0, icr_wr = 1'b0, pin = 1'b0;
  logic [2:0]        cfg = 3'h0;
  logic [1:0]        mode1 = 2'h0, mode2 = 2'h0;
  dht_pkg::dht_ctl_t ctl = '0;
  dht_pkg::dht_irq_t mask = '0, icr = '0;
  logic [31:0]       load = 32'h0, match = 32'h0;
  logic [15:0]       load2 = 16'h0, pre = 16'h0;
  logic [2:0]        cfg_o;
  dht_pkg::dht_ctl_t ctl_o;
  logic [31:0]       load_o, count_o, match_o;
  logic [15:0]       pre_o;
  dht_pkg::dht_irq_t raw_o, mis_o;
  logic              irq_o, trig_o;
  int                failures = 0;
  int                checks_done = 0;
  int                cyc = 0;
  // Small divider keeps each real-time tick a few pin periods long
  dht_timer #(.RTC_DIV(4)) dut (
    .CORE_CLK_I(clk), .RST_N_I(rst_n), .CFG_WR_I(cfg_wr), .CFG_I(cfg),
    .FIRST_MODE_I(mode1), .SECOND_MODE_I(mode2), .CTL_WR_I(ctl_wr), .CTL_I(ctl),
    .LOAD_WR_I(load_wr), .LOAD_I(load), .SECOND_LOAD_WR_I(load2_wr),
    .SECOND_LOAD_I(load2), .MATCH_WR_I(match_wr), .MATCH_I(match),
    .PRESCALE_WR_I(pre_wr), .PRESCALE_I(pre), .MASK_I(mask), .ICR_WR_I(icr_wr),
    .ICR_I(icr), .CAPTURE_PIN_I(pin), .CFG_O(cfg_o), .CTL_O(ctl_o), .LOAD_O(load_o),
    .COUNT_O(count_o), .MATCH_O(match_o), .PRESCALE_O(pre_o), .RAW_O(raw_o),
    .MIS_O(mis_o), .IRQ_O(irq_o), .TRIG_O(trig_o)
  );
  always #50 clk = ~clk;
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  task automatic step(input logic [31:0] exp_cnt);
    @(negedge clk);
    `CHK("count", exp_cnt, count_o)
  endtask
  // Pin rises every 8 core cycles, well inside the synchroniser's reach
  task automatic pin_edges(input int n);
    repeat (n) begin
      pin = 1'b1;
      repeat (4) @(negedge clk);
      pin = 1'b0;
      repeat (4) @(negedge clk);
    end
    repeat (4) @(negedge clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    `CHK("cfg", 3'h0, cfg_o)
    `CHK("ctl", dht_pkg::RST_CTL, ctl_o)
    `CHK("count", 32'hffff_ffff, count_o)
    `CHK("load", 32'hffff_ffff, load_o)
    `CHK("prescale", 16'h0000, pre_o)
    `CHK("raw", dht_pkg::RST_IRQ, raw_o)
    pre = 16'h1234;
    pulse(pre_wr);
    `CHK("prescale", 16'h1234, pre_o)
    $display("test reset done");
    mode1 = dht_pkg::MODE_ONESHOT;
    mode2 = dht_pkg::MODE_PERIODIC;
    mask.first_timeout = 1'b1;
    cfg = dht_pkg::CFG_JOINED;
    pulse(cfg_wr);
    load = 32'h0005_0003;
    pulse(load_wr);
    `CHK("load", 32'h0005_0003, load_o)
    `CHK("count", 32'h0005_0003, count_o)
    load = 32'h0000_0002;
    // Let an edge pass so the strobe is not lowered and raised in one step
    @(negedge clk);
    pulse(load_wr);
    ctl.first_half_enable = 1'b1;
    ctl.output_trigger_enable = 1'b1;
    pulse(ctl_wr);
    `CHK("count", 32'h0000_0002, count_o)
    step(32'h1);
    step(32'h0);
    step(32'h2);
    `CHK("raw", 1'b1, raw_o.first_timeout)
    `CHK("mis", 1'b1, mis_o.first_timeout)
    `CHK("irq", 1'b1, irq_o)
    `CHK("trig", 1'b1, trig_o)
    `CHK("enable", 1'b0, ctl_o.first_half_enable)
    step(32'h2);
    `CHK("trig", 1'b0, trig_o)
    `CHK("raw", 1'b1, raw_o.first_timeout)
    icr = 3'h1;
    pulse(icr_wr);
    `CHK("raw", 1'b0, raw_o.first_timeout)
    `CHK("irq", 1'b0, irq_o)
    $display("test joined one-shot done");
    mode1 = dht_pkg::MODE_PERIODIC;
    mode2 = dht_pkg::MODE_ONESHOT;
    mask = '0;
    ctl = '0;
    load = 32'h0001_0001;
    pulse(load_wr);
    ctl.first_half_enable = 1'b1;
    pulse(ctl_wr);
    step(32'h0001_0000);
    step(32'h0000_ffff);
    ctl.first_stall_bit = 1'b1;
    pulse(ctl_wr);
    repeat (3) step(32'h0000_fffe);
    ctl.first_stall_bit = 1'b0;
    pulse(ctl_wr);
    step(32'h0000_fffd);
    load = 32'h0000_0001;
    pulse(load_wr);
    `CHK("count", 32'h1, count_o)
    step(32'h0);
    step(32'h1);
    `CHK("trig", 1'b0, trig_o)
    `CHK("mis", 1'b0, mis_o.first_timeout)
    step(32'h0);
    step(32'h1);
    `CHK("enable", 1'b1, ctl_o.first_half_enable)
    `CHK("raw", 1'b1, raw_o.first_timeout)
    ctl = '0;
    pulse(ctl_wr);
    $display("test joined periodic done");
    cfg = dht_pkg::CFG_SPLIT;
    pulse(cfg_wr);
    `CHK("cfg", 3'h4, cfg_o)
    load = 32'h0009_0002;
    pulse(load_wr);
    load2 = 16'h0004;
    pulse(load2_wr);
    `CHK("load", 32'h0004_0002, load_o)
    mode2 = dht_pkg::MODE_PERIODIC;
    ctl.second_half_enable = 1'b1;
    pulse(ctl_wr);
    step(32'h0003_0002);
    step(32'h0002_0002);
    mode2 = dht_pkg::MODE_ONESHOT;
    ctl.first_half_enable = 1'b1;
    ctl.second_trigger_enable = 1'b1;
    pulse(ctl_wr);
    step(32'h0000_0001);
    step(32'h0004_0000);
    `CHK("trig", 1'b1, trig_o)
    `CHK("enable", 1'b0, ctl_o.second_half_enable)
    `CHK("raw", 1'b1, raw_o.second_timeout)
    step(32'h0004_0002);
    `CHK("trig", 1'b0, trig_o)
    `CHK("enable", 1'b1, ctl_o.first_half_enable)
    ctl = '0;
    pulse(ctl_wr);
    $display("test split done");
    match = 32'h0000_0002;
    pulse(match_wr);
    `CHK("match", 32'h2, match_o)
    cfg = dht_pkg::CFG_RTC;
    pulse(cfg_wr);
    `CHK("count", dht_pkg::RTC_FIRST, count_o)
    mask = '0;
    mask.clock_match = 1'b1;
    ctl.first_half_enable = 1'b1;
    ctl.clock_run_enable = 1'b1;
    ctl.first_stall_bit = 1'b1;
    ctl.second_stall_bit = 1'b1;
    pulse(ctl_wr);
    load = 32'h0000_0009;
    pulse(load_wr);
    `CHK("count", 32'h1, count_o)
    pin_edges(4);
    `CHK("count", 32'h2, count_o)
    pin_edges(4);
    `CHK("count", 32'h0, count_o)
    `CHK("raw", 1'b1, raw_o.clock_match)
    `CHK("mis", 1'b1, mis_o.clock_match)
    `CHK("irq", 1'b1, irq_o)
    pin_edges(4);
    `CHK("count", 32'h1, count_o)
    icr = '0;
    icr.clock_match = 1'b1;
    pulse(icr_wr);
    `CHK("raw", 1'b0, raw_o.clock_match)
    `CHK("mis", 1'b0, mis_o.clock_match)
    ctl = '0;
    pulse(ctl_wr);
    pin_edges(4);
    `CHK("count", 32'h1, count_o)
    $display("test real-time clock done");
    print_verdict();
  end
endmodule
